/* design/ssm_pkg.sv */
package ssm_pkg;
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned DIV_W       = 8;
  localparam int unsigned SYNC_MULT   = 4;
  localparam int unsigned HALF_MULT   = SYNC_MULT / 2;
  localparam int unsigned BIT_CNT_W   = 4;
  localparam logic        CLK_IDLE    = 1'b0;
  localparam logic        DATA_IDLE   = 1'b0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [DIV_W+1:0]     PHASE_ZERO   = 10'h000;
  localparam logic [DIV_W+1:0]     PHASE_ONE    = 10'h001;

  typedef enum logic [1:0] {
    SSM_IDLE  = 2'b00,
    SSM_LEAD  = 2'b01,
    SSM_TRAIL = 2'b10
  } ssm_state_t;
endpackage

/* design/ssm_hold_if.sv */
interface ssm_hold_if #(
  parameter int unsigned W = 8
);
  logic         full;
  logic [W-1:0] data;
  logic         take;

  modport holder (output full, output data, input  take);
  modport user   (input  full, input  data, output take);
endinterface

/* design/ssm_hold_reg.sv */
module ssm_hold_reg #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk_in,
  input  wire logic         rstn_in,
  input  wire logic         clear_in,
  input  wire logic         wr_in,
  input  wire logic [W-1:0] wr_data_in,
  ssm_hold_if.holder        hold
);
  typedef struct packed {
    logic         full;
    logic [W-1:0] data;
  } ssm_hold_st_t;

  ssm_hold_st_t st_reg;
  ssm_hold_st_t st_next;

  always_comb begin
    st_next = st_reg;
    if (hold.take) begin
      st_next.full = 1'b0;
    end
    // A write in the take cycle refills the holder, nothing is lost
    if (wr_in) begin
      st_next.full = 1'b1;
      st_next.data = wr_data_in;
    end
    if (clear_in) begin
      st_next = '0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hold.full = st_reg.full;
  assign hold.data = st_reg.data;
endmodule

/* design/ssm_master_tx.sv */
module ssm_master_tx #(
  parameter int unsigned DATA_W = ssm_pkg::DATA_W,
  parameter int unsigned DIV_W  = ssm_pkg::DIV_W
) (
  input  wire logic              sys_clk_in,
  input  wire logic              rstn_in,
  input  wire logic              sync_select_in,
  input  wire logic              clock_source_master_in,
  input  wire logic              serial_port_enable_in,
  input  wire logic              single_receive_enable_in,
  input  wire logic              continuous_receive_enable_in,
  input  wire logic              high_speed_select_in,
  input  wire logic [DIV_W-1:0]  baud_divisor_in,
  input  wire logic              tx_holding_wr_in,
  input  wire logic [DATA_W-1:0] tx_holding_data_in,
  input  wire logic              serial_data_pin_in,
  input  wire logic              shift_clock_pin_in,
  output logic                   serial_data_pin_out,
  output logic                   serial_data_pin_oe_out,
  output logic                   shift_clock_pin_out,
  output logic                   shift_clock_pin_oe_out,
  output logic                   tx_holding_full_out,
  output logic                   tx_shift_empty_out,
  output logic                   slave_clock_mode_out
);
  localparam int unsigned PH_W = DIV_W + 2;

  typedef struct packed {
    ssm_pkg::ssm_state_t                state;
    logic [DATA_W-1:0]                  shifter;
    logic [ssm_pkg::BIT_CNT_W-1:0]      bits_left;
    logic [PH_W-1:0]                    phase;
    logic                               data_o;
    logic                               data_oe;
    logic                               clk_o;
    logic                               clk_oe;
    logic                               hold_full;
    logic                               shift_empty;
    logic                               slave_mode;
  } ssm_st_t;

  ssm_st_t st_reg;
  ssm_st_t st_next;

  ssm_hold_if #(.W(DATA_W)) hold ();

  logic rx_cfg;
  logic sync_on;
  logic master_tx;
  logic [PH_W-1:0] half_len;
  logic [PH_W-1:0] period_last;

  // Half a bit period: 2*(n+1) oscillator cycles, high speed bit unused
  function automatic logic [PH_W-1:0] half_period(
    input logic [DIV_W-1:0] div
  );
    half_period = PH_W'((ssm_pkg::HALF_MULT) * (int'(div) + 1));
  endfunction

  // Whole bit period 4*(n+1), one bit wider so the top divisor fits
  function automatic logic [PH_W:0] bit_period(
    input logic [DIV_W-1:0] div
  );
    bit_period = (PH_W + 1)'(ssm_pkg::SYNC_MULT * (int'(div) + 1));
  endfunction

  assign rx_cfg    = single_receive_enable_in |
                     continuous_receive_enable_in;
  assign sync_on   = sync_select_in & serial_port_enable_in;
  assign master_tx = sync_on & clock_source_master_in & ~rx_cfg;
  assign half_len  = half_period(baud_divisor_in);
  assign period_last = PH_W'(bit_period(baud_divisor_in) - 1'b1);

  ssm_hold_reg #(.W(DATA_W)) u_hold (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .clear_in   (~master_tx),
    .wr_in      (tx_holding_wr_in),
    .wr_data_in (tx_holding_data_in),
    .hold       (hold.holder)
  );

  // Shifter is reached only through the holder, never directly
  always_comb begin
    st_next = st_reg;
    hold.take = 1'b0;
    st_next.clk_oe  = sync_on & clock_source_master_in;
    st_next.data_oe = master_tx;
    st_next.slave_mode = sync_on & ~clock_source_master_in;
    st_next.hold_full = hold.full;
    case (st_reg.state)
      ssm_pkg::SSM_IDLE: begin
        st_next.clk_o = ssm_pkg::CLK_IDLE;
        if (master_tx && hold.full) begin
          hold.take = 1'b1;
          st_next.shifter   = hold.data;
          st_next.bits_left = ssm_pkg::BIT_CNT_W'(DATA_W);
          st_next.phase     = ssm_pkg::PHASE_ZERO;
          st_next.state     = ssm_pkg::SSM_LEAD;
        end
      end
      ssm_pkg::SSM_LEAD: begin
        // Leading edge: clock rises and the next bit appears together
        st_next.clk_o  = 1'b1;
        st_next.data_o = st_reg.shifter[0];
        st_next.shifter = st_reg.shifter >> 1;
        st_next.bits_left = st_reg.bits_left - 1'b1;
        st_next.phase  = ssm_pkg::PHASE_ONE;
        st_next.state  = ssm_pkg::SSM_TRAIL;
      end
      ssm_pkg::SSM_TRAIL: begin
        st_next.phase = st_reg.phase + 1'b1;
        // >= so a divisor change mid-bit cannot strand the counter
        if (st_reg.phase >= half_len) begin
          st_next.clk_o = ssm_pkg::CLK_IDLE;
        end
        // Lead cycle is phase zero, so the period is 4*(n+1) exactly
        if (st_reg.phase >= period_last) begin
          st_next.phase = ssm_pkg::PHASE_ZERO;
          if (st_reg.bits_left != ssm_pkg::BIT_CNT_ZERO) begin
            st_next.state = ssm_pkg::SSM_LEAD;
          end else if (hold.full) begin
            hold.take = 1'b1;
            st_next.shifter   = hold.data;
            st_next.bits_left = ssm_pkg::BIT_CNT_W'(DATA_W);
            st_next.state     = ssm_pkg::SSM_LEAD;
          end else begin
            st_next.state = ssm_pkg::SSM_IDLE;
          end
        end
      end
      default: begin
        st_next.state = ssm_pkg::SSM_IDLE;
      end
    endcase
    if (!master_tx) begin
      st_next.state  = ssm_pkg::SSM_IDLE;
      st_next.clk_o  = ssm_pkg::CLK_IDLE;
      st_next.data_o = ssm_pkg::DATA_IDLE;
      hold.take      = 1'b0;
    end
    st_next.shift_empty = (st_next.state == ssm_pkg::SSM_IDLE);
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      st_reg <= '0;
      st_reg.shift_empty <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign serial_data_pin_out    = st_reg.data_o;
  assign serial_data_pin_oe_out = st_reg.data_oe;
  assign shift_clock_pin_out    = st_reg.clk_o;
  assign shift_clock_pin_oe_out = st_reg.clk_oe;
  assign tx_holding_full_out    = st_reg.hold_full;
  assign tx_shift_empty_out     = st_reg.shift_empty;
  assign slave_clock_mode_out   = st_reg.slave_mode;

  logic unused_ok;
  assign unused_ok = high_speed_select_in ^ serial_data_pin_in ^
                     shift_clock_pin_in;

  // Count clock rises during one shifter load
  logic [ssm_pkg::BIT_CNT_W:0] rise_cnt;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || hold.take) begin
      rise_cnt <= '0;
    end else if (st_reg.state == ssm_pkg::SSM_LEAD) begin
      rise_cnt <= rise_cnt + 1'b1;
    end
  end

  // Cycles from one leading edge to the next, for the period check;
  // a divisor change mid-bit voids that bit's measurement
  logic [PH_W:0]    lead_gap;
  logic             gap_valid;
  logic [DIV_W-1:0] gap_div;
  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in || st_reg.state == ssm_pkg::SSM_IDLE) begin
      lead_gap  <= '0;
      gap_valid <= 1'b0;
      gap_div   <= '0;
    end else if (st_reg.state == ssm_pkg::SSM_LEAD) begin
      lead_gap  <= (PH_W + 1)'(1);
      gap_valid <= 1'b1;
      gap_div   <= baud_divisor_in;
    end else begin
      lead_gap <= lead_gap + 1'b1;
      if (baud_divisor_in != gap_div) begin
        gap_valid <= 1'b0;
      end
    end
  end

  property p_clk_count;
    @(posedge sys_clk_in) disable iff (!rstn_in)
      rise_cnt <= (ssm_pkg::BIT_CNT_W + 1)'(DATA_W);
  endproperty
  bit_count_a: assert property (p_clk_count)
    else $error("more clocks than data bits");

  idle_clock_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    st_reg.state == ssm_pkg::SSM_IDLE |=> shift_clock_pin_out == 1'b0)
    else $error("clock not idle");

  data_on_lead_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    $changed(serial_data_pin_out) && master_tx && $past(master_tx)
      |-> $rose(shift_clock_pin_out))
    else $error("data changed off leading edge");

  half_duplex_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    rx_cfg |=> !serial_data_pin_oe_out)
    else $error("data driven in receive mode");

  clk_drv_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    sync_on && clock_source_master_in |=> shift_clock_pin_oe_out)
    else $error("clock driver off");

  start_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    st_reg.state == ssm_pkg::SSM_IDLE && master_tx && hold.full
      ##1 master_tx |=> $rose(shift_clock_pin_out))
    else $error("start not immediate");

  lsb_first_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    st_reg.state == ssm_pkg::SSM_LEAD && master_tx
      |=> serial_data_pin_out == $past(st_reg.shifter[0]))
    else $error("bit order wrong");

  gate_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    !master_tx |=> st_reg.state == ssm_pkg::SSM_IDLE)
    else $error("shifting outside master transmit");

  bit_period_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    st_reg.state == ssm_pkg::SSM_LEAD && gap_valid
      |-> lead_gap == bit_period(gap_div))
    else $error("bit period wrong");

  drivers_on_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    master_tx |=> serial_data_pin_oe_out && shift_clock_pin_oe_out)
    else $error("transmit drivers off");

  bit_stable_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    st_reg.state != ssm_pkg::SSM_LEAD && master_tx
      |=> $stable(serial_data_pin_out))
    else $error("data moved between leading edges");

  take_empty_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    hold.take |-> st_reg.state == ssm_pkg::SSM_IDLE ||
      st_reg.bits_left == ssm_pkg::BIT_CNT_ZERO)
    else $error("holder taken while shifter busy");

  rx_clears_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    rx_cfg ##1 rx_cfg |=> !tx_holding_full_out)
    else $error("holder kept in receive mode");

  slave_mode_a: assert property (@(posedge sys_clk_in)
    disable iff (!rstn_in)
    sync_on && !clock_source_master_in
      |=> slave_clock_mode_out && !shift_clock_pin_oe_out)
    else $error("slave clocking not selected");

  cov_start_c: cover property (@(posedge sys_clk_in)
    $rose(shift_clock_pin_out));
  cov_b2b_c: cover property (@(posedge sys_clk_in)
    st_reg.state == ssm_pkg::SSM_TRAIL && hold.take);
  cov_rx_c: cover property (@(posedge sys_clk_in) rx_cfg && sync_on);
  cov_wait_c: cover property (@(posedge sys_clk_in)
    st_reg.state == ssm_pkg::SSM_TRAIL && hold.full);
  cov_period_c: cover property (@(posedge sys_clk_in)
    st_reg.state == ssm_pkg::SSM_LEAD && gap_valid);
endmodule

/* sim/ssm_slave_model.sv */
module ssm_slave_model (
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       clk_pin_in,
  input  wire logic       data_pin_in,
  output logic [7:0]      byte_out,
  output logic [7:0]      chars_out,
  output logic [7:0]      rises_out,
  output logic [7:0]      high_len_out,
  output logic [7:0]      low_len_out,
  output logic            glitch_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Listen only: this slave never drives the data line
  logic [7:0] shift_reg;
  logic [7:0] hcnt_reg;
  logic [7:0] lcnt_reg;
  logic [3:0] nbit_reg;
  logic       clk_d_reg;
  logic       dat_d_reg;

  always_ff @(posedge sys_clk_in) begin
    if (!rstn_in) begin
      {shift_reg, hcnt_reg, nbit_reg, clk_d_reg, dat_d_reg} <= '0;
      lcnt_reg <= '0;
      {byte_out, chars_out, rises_out, high_len_out} <= '0;
      {low_len_out, glitch_out} <= '0;
    end else begin
      clk_d_reg <= clk_pin_in;
      dat_d_reg <= data_pin_in;
      if (clk_pin_in && !clk_d_reg) begin
        rises_out <= rises_out + 8'h01;
        low_len_out <= lcnt_reg;
      end
      lcnt_reg <= clk_pin_in ? 8'h00 : lcnt_reg + 8'h01;
      hcnt_reg <= clk_pin_in ? hcnt_reg + 8'h01 : 8'h00;
      // Data must not move while the clock stays high; the rising edge or the low phase is allowed
      if (clk_pin_in && clk_d_reg && data_pin_in != dat_d_reg)
        glitch_out <= 1'b1;
      if (!clk_pin_in && clk_d_reg) begin
        high_len_out <= hcnt_reg;
        shift_reg <= {data_pin_in, shift_reg[7:1]};
        nbit_reg <= (nbit_reg == 4'h7) ? 4'h0 : nbit_reg + 4'h1;
        if (nbit_reg == 4'h7) begin
          byte_out <= {data_pin_in, shift_reg[7:1]};
          chars_out <= chars_out + 8'h01;
        end
      end
    end
  end
endmodule

/* sim/tb_sync_serial_master_tx.sv */
module tb_sync_serial_master_tx;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk, rstn, sync_sel, master, port_en, s_rx, c_rx, hs;
  logic [7:0] div, wdata, s_byte, s_chars, s_rises, s_hlen, s_llen;
  logic       wr, d_out, d_oe, c_out, c_oe, h_full, s_empty, slv;
  logic       tog = 1'b0;
  logic       s_glitch;
  wire        d_wire = d_oe ? d_out : tog;
  // Pull-down holds a released clock line at its idle level
  wire        c_wire = c_oe ? c_out : 1'b0;
  int         failures, n_checks;

  ssm_master_tx DUT (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .sync_select_in(sync_sel),
    .clock_source_master_in(master), .serial_port_enable_in(port_en),
    .single_receive_enable_in(s_rx), .continuous_receive_enable_in(c_rx),
    .high_speed_select_in(hs), .baud_divisor_in(div),
    .tx_holding_wr_in(wr), .tx_holding_data_in(wdata),
    .serial_data_pin_in(d_wire), .shift_clock_pin_in(c_wire),
    .serial_data_pin_out(d_out), .serial_data_pin_oe_out(d_oe),
    .shift_clock_pin_out(c_out), .shift_clock_pin_oe_out(c_oe),
    .tx_holding_full_out(h_full), .tx_shift_empty_out(s_empty),
    .slave_clock_mode_out(slv));

  ssm_slave_model slave (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .clk_pin_in(c_wire),
    .data_pin_in(d_wire), .byte_out(s_byte), .chars_out(s_chars),
    .rises_out(s_rises), .high_len_out(s_hlen), .low_len_out(s_llen),
    .glitch_out(s_glitch));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Released line shows a moving pattern, not a held value
  always @(posedge sys_clk) tog <= ~tog;

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cfg(input logic m, input logic sr, input logic cr,
                     input logic h, input logic [7:0] n);
    @(posedge sys_clk);
    {sync_sel, port_en} <= 2'b11;
    master <= m;
    s_rx <= sr;
    c_rx <= cr;
    hs <= h;
    div <= n;
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic put(input logic [7:0] d);
    @(posedge sys_clk);
    wr <= 1'b1;
    wdata <= d;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic wait_chars(input logic [7:0] n);
    int i;
    for (i = 0; i < 3000 && s_chars !== n; i++) @(posedge sys_clk);
    repeat (12) @(posedge sys_clk);
  endtask

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    #200us;
    failures++;
    results();
  end

  initial begin
    {rstn, sync_sel, master, port_en, s_rx, c_rx, hs, wr} = '0;
    {div, wdata} = '0;
    failures = 0;
    n_checks = 0;
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk("clk_oe", 8'h00, {7'h0, c_oe});
    chk("shift_empty", 8'h01, {7'h0, s_empty});
    $display("test reset done");
    cfg(1'b1, 1'b0, 1'b0, 1'b0, 8'h01);
    chk("clk_oe", 8'h01, {7'h0, c_oe});
    chk("data_oe", 8'h01, {7'h0, d_oe});
    put(8'h3c);
    repeat (4) @(posedge sys_clk);
    put(8'h81);
    repeat (2) @(posedge sys_clk);
    chk("holding_full", 8'h01, {7'h0, h_full});
    wait_chars(8'h01);
    chk("byte", 8'h3c, s_byte);
    wait_chars(8'h02);
    chk("byte", 8'h81, s_byte);
    chk("rises", 8'h10, s_rises);
    chk("high_len", 8'h04, s_hlen);
    chk("low_len", 8'h04, s_llen);
    chk("shift_empty", 8'h01, {7'h0, s_empty});
    chk("clk_idle", 8'h00, {7'h0, c_out});
    $display("test transmit done");
    cfg(1'b1, 1'b0, 1'b0, 1'b1, 8'h00);
    put(8'h01);
    wait_chars(8'h03);
    chk("byte", 8'h01, s_byte);
    chk("high_len", 8'h02, s_hlen);
    chk("low_len", 8'h02, s_llen);
    chk("rises", 8'h18, s_rises);
    chk("glitch", 8'h00, {7'h0, s_glitch});
    $display("test divisor done");
    for (int k = 1; k < 4; k++) begin
      cfg(1'b1, k[0], k[1], 1'b0, 8'h01);
      put(8'hff);
      repeat (60) @(posedge sys_clk);
      chk("data_oe", 8'h00, {7'h0, d_oe});
      chk("clk_oe", 8'h01, {7'h0, c_oe});
      chk("chars", 8'h03, s_chars);
    end
    $display("test receive mode done");
    cfg(1'b0, 1'b0, 1'b0, 1'b0, 8'h01);
    chk("slave_mode", 8'h01, {7'h0, slv});
    chk("clk_oe", 8'h00, {7'h0, c_oe});
    @(posedge sys_clk);
    port_en <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk("slave_mode", 8'h00, {7'h0, slv});
    $display("test slave mode done");
    results();
  end
endmodule
